// >>> core/flc_pkg.sv
package flc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ    = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned RAMP_FAST_NS   = 1000;
  localparam int unsigned RAMP_SLOW_NS   = 16000;
  localparam int unsigned RAMP_FAST_CYC  = (RAMP_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAMP_SLOW_CYC  = (RAMP_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] TMO_BASE_MS    = 11'h028;
  localparam logic [10:0] TMO_STEP_MS    = 11'h068;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_ENABLE   = 8'h01;
  localparam logic [7:0] REG_TIMING   = 8'h02;
  localparam logic [7:0] REG_FLASH_BR = 8'h03;
  localparam logic [7:0] REG_TORCH_BR = 8'h04;
  localparam logic [7:0] REG_FLAGS    = 8'h05;
  localparam logic [7:0] REG_CTRL     = 8'h06;
  localparam logic [7:0] REG_SHUTOFF  = 8'h50;

  localparam int EN_MODE_LSB     = 0;
  localparam int EN_STROBE_BIT   = 2;
  localparam int EN_ILIM_BIT     = 5;
  localparam int TIM_RAMP_BIT    = 0;
  localparam int TIM_TMO_LSB     = 1;
  localparam int TIM_VMON_LSB    = 5;
  localparam int CTL_SWRST_BIT   = 7;
  localparam int CTL_TXEN_BIT    = 6;
  localparam int CTL_TXFLAG_BIT  = 5;
  localparam int SHUT_ARM_BIT    = 3;
  localparam int FLG_TIMEOUT     = 0;
  localparam int FLG_UVLO        = 1;
  localparam int FLG_TSB         = 2;
  localparam int FLG_TSD         = 3;
  localparam int FLG_LED_SHORT   = 4;
  localparam int FLG_LED_OPEN    = 5;
  localparam int FLG_LED_HOT     = 6;

  localparam logic [7:0] RST_ENABLE   = 8'h00;
  localparam logic [7:0] RST_TIMING   = 8'h00;
  localparam logic [7:0] RST_FLASH_BR = 8'h00;
  localparam logic [7:0] RST_TORCH_BR = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_SHUTOFF  = 8'h00;
  localparam logic [7:0] RST_FLAGS    = 8'h00;

  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_IR      = 2'h1;
  localparam logic [1:0] MODE_TORCH   = 2'h2;
  localparam logic [1:0] MODE_FLASH   = 2'h3;

  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [2:0] MSB_IDX      = 3'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } flc_req_type;

  typedef struct packed {
    logic led_hot;
    logic led_open;
    logic led_short;
    logic tsd;
    logic tsb;
    logic uvlo;
  } flc_fault_type;

  typedef enum logic [1:0] {ST_STANDBY, ST_FLASH, ST_TORCH, ST_IR} flc_state_type;

  typedef enum logic [2:0] {L_IDLE, L_DEV, L_REG, L_WR, L_RD} flc_link_type;

endpackage

// >>> core/flc_core.sv
`timescale 1ns/100ps

// Functional notes
// - Flash target is one of 128 codes, lowest 11mA, highest 1.5A.
// - Mode field 11 written in enable register starts flash.
// - With strobe enabled and PA sync disabled, a rising strobe in standby starts an external flash.
// - Flash current code climbs one step at a time to flash code.
// - Register-started flash clears mode field when timeout expires.
// - Torch target is one of 256 codes, 1.0mA to 375mA.
// - Mode field 10 starts torch, stepping up to the torch code.
// - Timing register bit 0 selects torch ramp speed.
// - Torch ignores flash timeout and PA sync events.
// - Armed torch with strobe low turns LED off, clears mode field.
// - Mode field 01 selects IR mode while PA sync is disabled, starting in pass operation.
// - IR mode uses the flash brightness code as target.
// - In IR mode strobe level gates the current source on and off.
// - IR mode applies and removes current in a single step.
// - IR may boost while strobe high, returns to pass when low.
// - IR mode goes to standby on flash timer expiry.
// - Headroom present holds pass device on; otherwise boost switches.
// - Brightness, timeout, PA sync enable, current limit are writable.
// - Timeout, fault and PA sync flags are readable.
// - Flash code is seven bits at bits 6..0 of flash brightness.
// - Flash timer gives sixteen durations from 40ms to 1.6s.
module flc_core
  import flc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CLK_FREQ_HZ / MS_PER_S,
  parameter logic [6:0]  DEV_ADDR  = 7'h53
)(
  input  wire logic          clk_in,
  input  wire logic          resetn_in,
  input  wire logic          link_clk_in,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_out,
  input  wire logic          strobe_in,
  input  wire logic          headroom_ok_in,
  input  wire flc_fault_type fault_in,
  output logic [7:0]         led_code_out,
  output logic               led_en_out,
  output logic               boost_en_out,
  output logic               pass_on_out,
  output logic               ilim_high_out,
  output logic [2:0]         input_voltage_flash_monitor_thr_out
);

  // The millisecond prescaler is sixteen bits wide, so larger counts cannot be served.
  if (MS_CYCLES < 1 || MS_CYCLES > 65535)
  begin : g_bad_ms
    $error("MS_CYCLES must lie between 1 and 65535.");
  end

  // ****************************************************************
  // Link domain: reset and pin synchronisers
  // ****************************************************************
  // The link logic assumes link_clk_in runs continuously.
  logic         lrst_m_q, lrst_s_q;
  logic         scl_m_q, scl_s_q, scl_p_q;
  logic         sda_m_q, sda_s_q, sda_p_q;
  logic         ack_m_q, ack_s_q, ack_seen_q;
  logic         req_tgl_q;
  flc_req_type  req_q;
  flc_link_type lst_q;
  logic [3:0]   cnt_q;
  logic [7:0]   shift_q;
  logic [7:0]   ptr_q;
  logic [7:0]   rbuf_q;
  logic         ackph_q;
  logic         ack_tgl_q;
  logic [7:0]   rdata_q;

  always_ff @(posedge link_clk_in)
  begin
    lrst_m_q <= resetn_in;
    lrst_s_q <= lrst_m_q;
  end

  always_ff @(posedge link_clk_in)
  begin
    scl_m_q <= scl_in;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_in;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // Read data is taken only after the core has answered the request.
  always_ff @(posedge link_clk_in)
  begin
    if (!lrst_s_q)
    begin
      ack_m_q    <= 1'b0;
      ack_s_q    <= 1'b0;
      ack_seen_q <= 1'b0;
      rbuf_q     <= 8'h00;
    end
    else
    begin
      ack_m_q <= ack_tgl_q;
      ack_s_q <= ack_m_q;
      if (ack_s_q != ack_seen_q)
      begin
        ack_seen_q <= ack_s_q;
        rbuf_q     <= rdata_q;
      end
    end
  end

  // ****************************************************************
  // Link domain: serial register port
  // ****************************************************************
  always_ff @(posedge link_clk_in)
  begin
    if (!lrst_s_q)
    begin
      lst_q      <= L_IDLE;
      cnt_q      <= 4'h0;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      ackph_q    <= 1'b0;
      sda_oe_out <= 1'b0;
      req_q      <= '0;
      req_tgl_q  <= 1'b0;
    end
    else if (start_c)
    begin
      lst_q      <= L_DEV;
      cnt_q      <= 4'h0;
      ackph_q    <= 1'b0;
      sda_oe_out <= 1'b0;
    end
    else if (stop_c)
    begin
      lst_q      <= L_IDLE;
      ackph_q    <= 1'b0;
      sda_oe_out <= 1'b0;
    end
    else if (scl_rise && lst_q != L_IDLE)
    begin
      if (ackph_q)
      begin
        if (lst_q == L_RD && sda_s_q)
          lst_q <= L_IDLE;
      end
      else
      begin
        shift_q <= {shift_q[6:0], sda_s_q};
        cnt_q   <= cnt_q + 4'h1;
      end
    end
    else if (scl_fall && lst_q != L_IDLE)
    begin
      if (ackph_q)
      begin
        ackph_q    <= 1'b0;
        cnt_q      <= 4'h0;
        sda_oe_out <= (lst_q == L_RD) ? ~rbuf_q[MSB_IDX] : 1'b0;
      end
      else if (lst_q == L_RD)
      begin
        if (cnt_q == BYTE_BITS)
        begin
          sda_oe_out <= 1'b0;
          ackph_q    <= 1'b1;
          ptr_q      <= ptr_q + 8'h01;
          req_q      <= '{wr: 1'b0, addr: ptr_q + 8'h01, data: 8'h00};
          req_tgl_q  <= ~req_tgl_q;
        end
        else
          sda_oe_out <= ~rbuf_q[MSB_IDX - cnt_q[2:0]];
      end
      else if (cnt_q == BYTE_BITS)
      begin
        case (lst_q)
          L_DEV:
          begin
            if (shift_q[7:1] == DEV_ADDR)
            begin
              ackph_q    <= 1'b1;
              sda_oe_out <= 1'b1;
              if (shift_q[0])
              begin
                lst_q     <= L_RD;
                req_q     <= '{wr: 1'b0, addr: ptr_q, data: 8'h00};
                req_tgl_q <= ~req_tgl_q;
              end
              else
                lst_q <= L_REG;
            end
            else
              lst_q <= L_IDLE;
          end
          L_REG:
          begin
            ptr_q      <= shift_q;
            ackph_q    <= 1'b1;
            sda_oe_out <= 1'b1;
            lst_q      <= L_WR;
          end
          L_WR:
          begin
            req_q      <= '{wr: 1'b1, addr: ptr_q, data: shift_q};
            req_tgl_q  <= ~req_tgl_q;
            ptr_q      <= ptr_q + 8'h01;
            ackph_q    <= 1'b1;
            sda_oe_out <= 1'b1;
          end
          default:
            lst_q <= L_IDLE;
        endcase
      end
    end
  end

  assign sda_out = 1'b0;

  // ****************************************************************
  // Core domain: synchronisers and request handshake
  // ****************************************************************
  logic          req_m_q, req_s_q, req_seen_q;
  logic          strobe_m_q, strobe_s_q, strobe_p_q;
  logic          hr_m_q, hr_s_q;
  flc_fault_type flt_m_q, flt_s_q;

  always_ff @(posedge clk_in)
  begin
    req_m_q    <= req_tgl_q;
    req_s_q    <= req_m_q;
    strobe_m_q <= strobe_in;
    strobe_s_q <= strobe_m_q;
    strobe_p_q <= strobe_s_q;
    hr_m_q     <= headroom_ok_in;
    hr_s_q     <= hr_m_q;
    flt_m_q    <= fault_in;
    flt_s_q    <= flt_m_q;
  end

  wire req_go  = req_s_q ^ req_seen_q;
  wire wr_go   = req_go & req_q.wr;
  wire rd_go   = req_go & ~req_q.wr;
  wire st_rise = strobe_s_q & ~strobe_p_q;

  // ****************************************************************
  // Core domain: register file
  // ****************************************************************
  logic [7:0]    enable_q, timing_q, flash_br_q, torch_br_q, ctrl_q, shutoff_q, flags_q;
  logic          clr_mode;
  logic          tmo_evt;
  logic          tx_evt;
  flc_state_type state_q;

  wire sw_reset = wr_go && req_q.addr == REG_CTRL && req_q.data[CTL_SWRST_BIT];
  wire [1:0] mode_field = enable_q[EN_MODE_LSB +: 2];
  wire       tx_en      = ctrl_q[CTL_TXEN_BIT];

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || sw_reset)
    begin
      timing_q   <= RST_TIMING;
      flash_br_q <= RST_FLASH_BR;
      torch_br_q <= RST_TORCH_BR;
      shutoff_q  <= RST_SHUTOFF;
    end
    else if (wr_go)
    begin
      case (req_q.addr)
        REG_TIMING:   timing_q   <= req_q.data;
        REG_FLASH_BR: flash_br_q <= {1'b0, req_q.data[6:0]};
        REG_TORCH_BR: torch_br_q <= req_q.data;
        REG_SHUTOFF:  shutoff_q  <= req_q.data;
        default:      ;
      endcase
    end
  end

  // A fresh mode write beats a hardware clear in the same cycle.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || sw_reset)
      enable_q <= RST_ENABLE;
    else if (wr_go && req_q.addr == REG_ENABLE)
      enable_q <= req_q.data;
    else if (clr_mode)
      enable_q[EN_MODE_LSB +: 2] <= MODE_STANDBY;
  end

  // Hardware-set flags win over the read that clears them.
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || sw_reset)
    begin
      flags_q <= RST_FLAGS;
      ctrl_q  <= RST_CTRL;
    end
    else
    begin
      flags_q <= (rd_go && req_q.addr == REG_FLAGS ? 8'h00 : flags_q)
               | {1'b0, flt_s_q.led_hot, flt_s_q.led_open, flt_s_q.led_short,
                  flt_s_q.tsd, flt_s_q.tsb, flt_s_q.uvlo, tmo_evt};
      if (wr_go && req_q.addr == REG_CTRL)
        ctrl_q <= {1'b0, req_q.data[CTL_TXEN_BIT], ctrl_q[CTL_TXFLAG_BIT] | tx_evt,
                   req_q.data[4:0]};
      else
        ctrl_q[CTL_TXFLAG_BIT] <= (rd_go && req_q.addr == REG_CTRL ? 1'b0
                                   : ctrl_q[CTL_TXFLAG_BIT]) | tx_evt;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      req_seen_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
      rdata_q    <= 8'h00;
    end
    else if (req_go)
    begin
      req_seen_q <= req_s_q;
      ack_tgl_q  <= ~ack_tgl_q;
      case (req_q.addr)
        REG_ENABLE:   rdata_q <= enable_q;
        REG_TIMING:   rdata_q <= timing_q;
        REG_FLASH_BR: rdata_q <= flash_br_q;
        REG_TORCH_BR: rdata_q <= torch_br_q;
        REG_FLAGS:    rdata_q <= flags_q;
        REG_CTRL:     rdata_q <= ctrl_q;
        REG_SHUTOFF:  rdata_q <= shutoff_q;
        default:      rdata_q <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Core domain: flash timer
  // ****************************************************************
  logic [15:0] pre_q;
  logic [10:0] ms_q;
  wire  [10:0] tmo_lim = TMO_BASE_MS + TMO_STEP_MS * {7'h00, timing_q[TIM_TMO_LSB +: 4]};
  wire         timing_on = state_q == ST_FLASH || state_q == ST_IR;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || !timing_on)
    begin
      pre_q <= 16'h0000;
      ms_q  <= 11'h000;
    end
    else if (pre_q == 16'(MS_CYCLES - 1))
    begin
      pre_q <= 16'h0000;
      if (ms_q != tmo_lim)
        ms_q <= ms_q + 11'h001;
    end
    else
      pre_q <= pre_q + 16'h0001;
  end

  assign tmo_evt = timing_on && ms_q == tmo_lim;

  // ****************************************************************
  // Core domain: mode sequencer
  // ****************************************************************
  logic ext_q;
  wire  hard_fault = flt_s_q.tsd | flt_s_q.uvlo | flt_s_q.led_short;
  wire  armed      = shutoff_q[SHUT_ARM_BIT];

  always_comb
  begin
    clr_mode = 1'b0;
    if (hard_fault)
      clr_mode = 1'b1;
    else
      case (state_q)
        ST_FLASH: clr_mode = tmo_evt && !ext_q;
        ST_TORCH: clr_mode = armed && !strobe_s_q;
        ST_IR:    clr_mode = tmo_evt;
        default:  clr_mode = 1'b0;
      endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || sw_reset)
    begin
      state_q <= ST_STANDBY;
      ext_q   <= 1'b0;
    end
    else if (hard_fault)
      state_q <= ST_STANDBY;
    else
      case (state_q)
        ST_STANDBY:
        begin
          ext_q <= 1'b0;
          if (mode_field == MODE_FLASH)
            state_q <= ST_FLASH;
          else if (mode_field == MODE_TORCH)
            state_q <= ST_TORCH;
          else if (mode_field == MODE_IR && !tx_en)
            state_q <= ST_IR;
          else if (enable_q[EN_STROBE_BIT] && st_rise && !tx_en)
          begin
            state_q <= ST_FLASH;
            ext_q   <= 1'b1;
          end
        end
        ST_FLASH:
          if (tmo_evt || (ext_q ? !strobe_s_q : mode_field != MODE_FLASH))
            state_q <= ST_STANDBY;
        ST_TORCH:
          if (clr_mode || mode_field != MODE_TORCH)
            state_q <= ST_STANDBY;
        ST_IR:
          if (tmo_evt || mode_field != MODE_IR)
            state_q <= ST_STANDBY;
        default:
          state_q <= ST_STANDBY;
      endcase
  end

  // The PA sync pin only matters while a register-started flash runs.
  wire tx_high = tx_en && state_q == ST_FLASH && !ext_q && strobe_s_q;
  assign tx_evt = tx_en && state_q == ST_FLASH && !ext_q && st_rise;

  // ****************************************************************
  // Core domain: current ramp and converter control
  // ****************************************************************
  logic [7:0]  target;
  logic [11:0] rcnt_q;

  always_comb
  begin
    target = 8'h00;
    case (state_q)
      ST_FLASH:
        if (flt_s_q.tsb)
          target = {1'b0, torch_br_q[7:1]};
        else if (tx_high)
          target = torch_br_q;
        else
          target = flash_br_q;
      ST_TORCH: target = torch_br_q;
      ST_IR:    target = flash_br_q;
      default:  target = 8'h00;
    endcase
  end

  wire [11:0] rper = (state_q == ST_TORCH && timing_q[TIM_RAMP_BIT])
                   ? 12'(RAMP_SLOW_CYC) : 12'(RAMP_FAST_CYC);
  wire        rtick = rcnt_q >= rper - 12'h001;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || state_q == ST_STANDBY || rtick)
      rcnt_q <= 12'h000;
    else
      rcnt_q <= rcnt_q + 12'h001;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || state_q == ST_STANDBY)
    begin
      led_code_out <= 8'h00;
      led_en_out   <= 1'b0;
    end
    else if (state_q == ST_IR)
    begin
      led_code_out <= strobe_s_q ? target : 8'h00;
      led_en_out   <= strobe_s_q;
    end
    else
    begin
      led_en_out <= 1'b1;
      if (led_code_out > target)
        led_code_out <= target;
      else if (rtick && led_code_out != target)
        led_code_out <= led_code_out + 8'h01;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      boost_en_out <= 1'b0;
      pass_on_out  <= 1'b0;
    end
    else
    begin
      boost_en_out <= led_en_out && !hr_s_q;
      pass_on_out  <= state_q != ST_STANDBY && !(led_en_out && !hr_s_q);
    end
  end

  assign ilim_high_out = enable_q[EN_ILIM_BIT];
  assign input_voltage_flash_monitor_thr_out = timing_q[TIM_VMON_LSB +: 3];

endmodule

// >>> sim/flc_core_monitor.sv
`timescale 1ns/100ps
module flc_core_monitor
  import flc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10
)(
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       link_clk_in,
  input wire logic       scl_in,
  input wire logic       sda_oe_out,
  input wire logic       headroom_ok_in,
  input wire logic [7:0] led_code_out,
  input wire logic       led_en_out,
  input wire logic       boost_en_out,
  input wire logic       pass_on_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ****************************************************************
  // Ramp, converter and serial data line
  // ****************************************************************
  sequence s_rise;
    led_en_out && $past(led_en_out) && (led_code_out > $past(led_code_out));
  endsequence
  sequence s_step;
    led_en_out && $past(led_en_out) && (led_code_out == $past(led_code_out) + 8'h01);
  endsequence
  sequence s_hr_hi;
    headroom_ok_in [*4];
  endsequence
  sequence s_hr_lo;
    (!headroom_ok_in) [*4] ##0 led_en_out;
  endsequence
  property p_ramp_single;
    s_rise |-> s_step;
  endproperty
  // A flash or torch may be stopped at any time, so only a further rise is forbidden.
  property p_ramp_spacing;
    s_step |=> (!led_en_out || led_code_out <= $past(led_code_out)) [*8];
  endproperty
  property p_boost_excl;
    boost_en_out |-> !pass_on_out;
  endproperty
  property p_boost_lit;
    boost_en_out |-> $past(led_en_out);
  endproperty
  property p_hr_pass;
    s_hr_hi |=> !boost_en_out;
  endproperty
  property p_hr_boost;
    s_hr_lo |=> boost_en_out;
  endproperty
  property p_oe_scl_low;
    @(posedge link_clk_in) disable iff (!resetn_in)
      $changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_ramp_single: assert property (p_ramp_single)
    else $error("current code skipped a level");
  a_ramp_spacing: assert property (p_ramp_spacing)
    else $error("ramp steps too close");
  a_boost_excl: assert property (p_boost_excl)
    else $error("boost and pass on together");
  a_boost_lit: assert property (p_boost_lit)
    else $error("boost without lit led");
  a_hr_pass: assert property (p_hr_pass)
    else $error("boost despite headroom");
  a_hr_boost: assert property (p_hr_boost)
    else $error("no boost without headroom");
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data line moved while clock high");
endmodule

bind flc_core flc_core_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .clk_in(clk_in), .resetn_in(resetn_in), .link_clk_in(link_clk_in), .scl_in(scl_in),
  .sda_oe_out(sda_oe_out), .headroom_ok_in(headroom_ok_in), .led_code_out(led_code_out),
  .led_en_out(led_en_out), .boost_en_out(boost_en_out), .pass_on_out(pass_on_out));

// >>> sim/flc_host_model.sv
`timescale 1ns/100ps
module flc_host_model
#(
  parameter logic [6:0] DEV_ADDR = 7'h53
)(
  input  wire logic link_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // SDA idles released, so the pull-up holds it high; SCL idles driven high.
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick(int n);
    repeat (n) @(posedge link_clk_in);
  endtask
  task automatic put(logic b);
    sda_low_out <= !b;
    tick(6);
    scl_out <= 1'b1;
    tick(12);
    scl_out <= 1'b0;
    tick(6);
  endtask
  task automatic get(output logic b);
    sda_low_out <= 1'b0;
    tick(6);
    scl_out <= 1'b1;
    tick(6);
    b = sda_in;
    tick(6);
    scl_out <= 1'b0;
    tick(6);
  endtask
  task automatic start();
    sda_low_out <= 1'b0;
    tick(6);
    scl_out <= 1'b1;
    tick(12);
    sda_low_out <= 1'b1;
    tick(12);
    scl_out <= 1'b0;
    tick(6);
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    tick(6);
    scl_out <= 1'b1;
    tick(12);
    sda_low_out <= 1'b0;
    tick(12);
  endtask
  task automatic send(logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--)
      put(d[i]);
    get(a);
  endtask
  task automatic write_reg(logic [7:0] a, logic [7:0] d);
    start();
    send({DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask
  task automatic read_reg(logic [7:0] a, output logic [7:0] d);
    logic b;
    start();
    send({DEV_ADDR, 1'b0});
    send(a);
    start();
    send({DEV_ADDR, 1'b1});
    for (int i = 0; i < 8; i++)
    begin
      get(b);
      d = {d[6:0], b};
    end
    put(1'b1);
    stop();
  endtask
endmodule

// >>> sim/tb_flash_led_mode_controller.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_flash_led_mode_controller;
  import flc_pkg::*;
  logic       clk_in = 1'b0, resetn_in = 1'b0, link_clk_in = 1'b0;
  logic       strobe = 1'b0, headroom = 1'b1, scl, sda_low, sda_oe, sda;
  logic [7:0] code, d;
  logic       led_en, boost, pass_on, ilim, sda_drv;
  logic [2:0] vmon;
  flc_fault_type fault = 6'h00;
  int         err_total = 0, num_checks = 0, n, m;
  assign sda = !(sda_oe || sda_low);
  initial forever #20 clk_in = ~clk_in;
  initial
  begin
    #3;
    forever #6 link_clk_in = ~link_clk_in;
  end
  flc_core #(.MS_CYCLES(10)) u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .link_clk_in(link_clk_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
    .strobe_in(strobe), .headroom_ok_in(headroom), .fault_in(fault), .led_code_out(code),
    .led_en_out(led_en), .boost_en_out(boost), .pass_on_out(pass_on),
    .ilim_high_out(ilim), .input_voltage_flash_monitor_thr_out(vmon));
  flc_host_model u_host (.link_clk_in(link_clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));
  task automatic wr(logic [7:0] a, logic [7:0] v);
    u_host.write_reg(a, v);
    repeat (8) @(negedge clk_in);
  endtask
  task automatic wait_code(logic [7:0] c, int lim, output int k);
    k = 0;
    while (code !== c && k < lim)
    begin
      @(negedge clk_in);
      k++;
    end
  endtask
  task automatic wait_en(logic v, int lim, output int k);
    k = 0;
    while (led_en !== v && k < lim)
    begin
      @(negedge clk_in);
      k++;
    end
  endtask
  task automatic t_regs();
    u_host.read_reg(REG_ENABLE, d);
    `CHK("enable", RST_ENABLE, d)
    wr(REG_FLASH_BR, 8'hff);
    u_host.read_reg(REG_FLASH_BR, d);
    `CHK("flash_br", 8'h7f, d)
    wr(REG_TIMING, 8'hb4);
    u_host.read_reg(REG_TIMING, d);
    `CHK("timing", 8'hb4, d)
    `CHK("vmon", 3'h5, vmon)
    `CHK("sda_drv", 1'b0, sda_drv)
    wr(REG_ENABLE, 8'h20);
    `CHK("ilim", 1'b1, ilim)
    u_host.read_reg(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    wr(REG_ENABLE, 8'h00);
    wr(REG_TIMING, 8'h00);
    fault = 6'h20;
    u_host.read_reg(REG_FLAGS, d);
    `CHK("hot_flag", 8'h40, d)
    @(negedge clk_in) fault = 6'h00;
  endtask
  task automatic t_flash();
    wr(REG_FLASH_BR, 8'h05);
    // The mode write lands before its STOP, so the lit time is timed from the LED turning on.
    fork
      u_host.write_reg(REG_ENABLE, {6'h00, MODE_FLASH});
      begin
        wait_en(1'b1, 300, n);
        wait_code(8'h05, 300, m);
      end
    join
    `CHK("flash_code", 8'h05, code)
    wait_en(1'b0, 600, n);
    `CHK("flash_len", 1'b1, (m + n >= 390 && m + n <= 410))
    u_host.read_reg(REG_ENABLE, d);
    `CHK("flash_mode", MODE_STANDBY, d[1:0])
    u_host.read_reg(REG_FLAGS, d);
    `CHK("tmo_flag", 1'b1, d[FLG_TIMEOUT])
    u_host.read_reg(REG_FLAGS, d);
    `CHK("flag_clear", 8'h00, d)
  endtask
  task automatic t_torch();
    wr(REG_TIMING, 8'h01);
    wr(REG_TORCH_BR, 8'h03);
    u_host.write_reg(REG_ENABLE, {6'h00, MODE_TORCH});
    wait_code(8'h01, 900, n);
    wait_code(8'h02, 900, n);
    `CHK("slow_step", 400, n)
    wait_code(8'h03, 900, n);
    wr(REG_CTRL, 8'h40);
    strobe = 1'b1;
    repeat (600) @(negedge clk_in);
    `CHK("torch_code", 8'h03, code)
    `CHK("torch_lit", 1'b1, led_en)
    u_host.read_reg(REG_CTRL, d);
    `CHK("torch_tx", 8'h40, d)
    @(negedge clk_in) strobe = 1'b0;
    wr(REG_CTRL, 8'h00);
    wr(REG_ENABLE, 8'h00);
    wr(REG_TIMING, 8'h00);
  endtask
  task automatic t_shutoff();
    wr(REG_SHUTOFF, 8'h08);
    strobe = 1'b1;
    wr(REG_ENABLE, {6'h00, MODE_TORCH});
    wait_code(8'h03, 300, n);
    `CHK("armed_lit", 1'b1, led_en)
    strobe = 1'b0;
    wait_en(1'b0, 20, n);
    `CHK("shutoff", 1'b0, led_en)
    u_host.read_reg(REG_ENABLE, d);
    `CHK("shut_mode", MODE_STANDBY, d[1:0])
    wr(REG_SHUTOFF, 8'h00);
  endtask
  task automatic t_ir();
    wr(REG_FLASH_BR, 8'h09);
    wr(REG_ENABLE, {6'h00, MODE_IR});
    `CHK("ir_dark", 1'b0, led_en)
    `CHK("ir_pass", 1'b1, pass_on)
    headroom = 1'b0;
    strobe = 1'b1;
    wait_en(1'b1, 10, n);
    `CHK("ir_jump", 8'h09, code)
    repeat (6) @(negedge clk_in);
    `CHK("ir_boost", 1'b1, boost)
    strobe = 1'b0;
    wait_en(1'b0, 10, n);
    `CHK("ir_gate", 1'b0, led_en)
    repeat (4) @(negedge clk_in);
    `CHK("ir_unboost", 1'b0, boost)
    headroom = 1'b1;
    strobe = 1'b1;
    wait_en(1'b1, 10, n);
    wait_en(1'b0, 600, n);
    `CHK("ir_expire", 1'b0, led_en)
    u_host.read_reg(REG_ENABLE, d);
    `CHK("ir_mode", MODE_STANDBY, d[1:0])
    @(negedge clk_in) strobe = 1'b0;
  endtask
  task automatic t_ext();
    wr(REG_ENABLE, 8'h04);
    strobe = 1'b1;
    wait_code(8'h09, 400, n);
    `CHK("ext_code", 8'h09, code)
    strobe = 1'b0;
    wait_en(1'b0, 20, n);
    `CHK("ext_off", 1'b0, led_en)
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // The transfers dominate the run, so the limit is about eight times their sum.
  initial
  begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_regs();
    t_flash();
    t_torch();
    t_shutoff();
    t_ir();
    t_ext();
    give_verdict();
  end
endmodule
